// ### logic/fca_abort.v
// Interrupt-driven abort detection for write, erase and signature operations.
// Assumes interrupt lines are synchronous levels in the system clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "fca_map.vh"

module fca_abort #(
	parameter IRQ_N = `FCA_IRQ_N
)
(
	// System
	input wire clk_i,
	input wire rst_i,
	// Enables and request lines
	input wire [IRQ_N-1:0] aen_i,
	input wire [IRQ_N-1:0] irq_i,
	input wire op_active_i,
	// Abort event
	output wire trig_o,
	output reg abort_o
);

reg hit_prev_r;
wire hit_w;

// An enabled interrupt kills an operation in progress
assign hit_w = op_active_i & (|(aen_i & irq_i));
// Only the first cycle of a hit counts, so one abort per assertion
assign trig_o = hit_w & ~hit_prev_r;

always @(posedge clk_i)
begin
	if (rst_i)
	begin
		hit_prev_r <= 1'b0;
		abort_o <= 1'b0;
	end
	else
	begin
		hit_prev_r <= hit_w;
		abort_o <= trig_o;
	end
end

endmodule
`default_nettype wire

// ### logic/fca_map.vh
// Register map, field layout, reset values and key words for the flash auxiliary registers.
// Included by every design file of this block; definitions only.
`ifndef FCA_MAP_VH
`define FCA_MAP_VH

// Byte addresses on the register bus
`define FCA_ADR_PAGE0 32'h4001c010
`define FCA_ADR_PAGE1 32'h4001c018
`define FCA_ADR_KEY 32'h4001c020
`define FCA_ADR_SIG_LOW_FIELD 32'h4001c030
`define FCA_ADR_SIG_HIGH_FIELD 32'h4001c034
`define FCA_ADR_ABTL 32'h4001c048
`define FCA_ADR_ABTH 32'h4001c04c
`define FCA_ADR_AEN0 32'h4001c078
`define FCA_ADR_AEN1 32'h4001c07c
`define FCA_ADR_AEN2 32'h4001c080
`define FCA_ADR_AEN3 32'h4001c084

// Page address field
`define FCA_PAGE_MSB 13
`define FCA_PAGE_LSB 9
`define FCA_PAGE_W 5

// Abort enable layout
`define FCA_AEN3_W 13
`define FCA_IRQ_N 61

// Unlock key words, in order
`define FCA_KEY_FIRST 16'hf456
`define FCA_KEY_SECOND 16'hf123

// Reset values
`define FCA_RST_HALF 16'h0000
`define FCA_RST_PAGE 5'h00
`define FCA_RST_AEN3 13'h0000

`endif

// ### logic/fca_regs.v
// Auxiliary registers of the flash command controller, on a classic Wishbone slave.
// Assumes a 32-bit Wishbone master on the same clock and a controller that issues the commands.
// Interrupt lines and flash status inputs are taken as synchronous to clk_i.
// What this block does
// - Page address registers hold a writable five-bit page field at bits 13:9.
// - Page address bits 8:0 ignore writes and read zero.
// - Page address bits 15:14 are reserved and read zero.
// - Key register is write-only and always reads zero.
// - Lower signature register shows signature bits 15:0, read-only.
// - Upper signature register shows signature bits 31:16, read-only.
// - An aborted write captures its address; lower half writable, upper read-only.
// - A set abort enable lets its interrupt abort a write, erase or signature.
// - Enables for interrupts 0-47 fill three registers; 48-60 use bits 12:0.
// - Page, key, lower signature and abort enable registers reset to zero.
// - Mass erase and signature commands need the completed key unlock; interrupt aborts do not.
`timescale 1ns/1ps
`default_nettype none
`include "fca_map.vh"

module fca_regs #(
	parameter IRQ_N = `FCA_IRQ_N
)
(
	// System
	input wire clk_i,
	input wire rst_i,
	// Wishbone slave
	input wire [31:0] adr_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	input wire we_i,
	input wire [3:0] sel_i,
	input wire cyc_i,
	input wire stb_i,
	output reg ack_o,
	// Page addresses to the command engine
	output wire [4:0] first_page_addr_o,
	output wire [4:0] second_page_addr_o,
	// Protected command handshake
	input wire prot_req_i,
	output wire prot_ok_o,
	output wire unlocked_o,
	// Signature result
	input wire sig_load_i,
	input wire [31:0] sig_value_i,
	// Flash write in progress
	input wire write_active_i,
	input wire [31:0] write_addr_i,
	input wire op_active_i,
	// System interrupt lines and abort
	input wire [IRQ_N-1:0] irq_i,
	output wire abort_o
);

// Merges a 16-bit write into an old value, by byte lane
function [15:0] lane_merge;
	input [15:0] old_v;
	input [15:0] new_v;
	input [1:0] sel;
	begin
		lane_merge = old_v;
		if (sel[0])
			lane_merge[7:0] = new_v[7:0];
		if (sel[1])
			lane_merge[15:8] = new_v[15:8];
	end
endfunction

// Full 32-bit compare, so aliases of the block never answer
function adr_match;
	input [31:0] adr;
	input [31:0] base;
	begin
		adr_match = (adr == base);
	end
endfunction

// Places a page field at bits 13:9 of a halfword
function [15:0] page_view;
	input [4:0] pg;
	begin
		page_view = 16'h0000;
		page_view[`FCA_PAGE_MSB:`FCA_PAGE_LSB] = pg;
	end
endfunction

reg [4:0] page0_r;
reg [4:0] page1_r;
reg [15:0] sig_lo_r;
reg [15:0] sig_hi_r;
reg [15:0] abt_lo_r;
reg [15:0] abt_hi_r;
reg [15:0] aen0_r;
reg [15:0] aen1_r;
reg [15:0] aen2_r;
reg [12:0] aen3_r;

wire req_w;
wire wr_w;
wire [15:0] wdat_w;
wire [15:0] page_wr_w;
wire sel_page0_w;
wire sel_page1_w;
wire sel_key_w;
wire sel_sig_low_field_w;
wire sel_sig_high_field_w;
wire sel_abtl_w;
wire sel_abth_w;
wire sel_aen0_w;
wire sel_aen1_w;
wire sel_aen2_w;
wire sel_aen3_w;
wire key_wr_w;
wire abort_trig_w;
wire [IRQ_N-1:0] aen_all_w;
wire [15:0] aen3_wr_w;
reg [15:0] rdat_w;

// A request is taken once; ack falls in the cycle after it is given
assign req_w = cyc_i & stb_i & ~ack_o;
assign wr_w = req_w & we_i;
assign wdat_w = dat_i[15:0];

assign sel_page0_w = adr_match(adr_i, `FCA_ADR_PAGE0);
assign sel_page1_w = adr_match(adr_i, `FCA_ADR_PAGE1);
assign sel_key_w = adr_match(adr_i, `FCA_ADR_KEY);
assign sel_sig_low_field_w = adr_match(adr_i, `FCA_ADR_SIG_LOW_FIELD);
assign sel_sig_high_field_w = adr_match(adr_i, `FCA_ADR_SIG_HIGH_FIELD);
assign sel_abtl_w = adr_match(adr_i, `FCA_ADR_ABTL);
assign sel_abth_w = adr_match(adr_i, `FCA_ADR_ABTH);
assign sel_aen0_w = adr_match(adr_i, `FCA_ADR_AEN0);
assign sel_aen1_w = adr_match(adr_i, `FCA_ADR_AEN1);
assign sel_aen2_w = adr_match(adr_i, `FCA_ADR_AEN2);
assign sel_aen3_w = adr_match(adr_i, `FCA_ADR_AEN3);

// The key register has no storage; the unlock state lives in the sequencer
// Key words count only when both low lanes are written, so a split word cannot half-match
assign key_wr_w = wr_w & sel_key_w & sel_i[0] & sel_i[1];

assign first_page_addr_o = page0_r;
assign second_page_addr_o = page1_r;

assign aen_all_w = {aen3_r, aen2_r, aen1_r, aen0_r};

// Page write value; only bits 13:9 survive
assign page_wr_w = wdat_w;

// Reserved bits 15:13 are merged as zero and then dropped
assign aen3_wr_w = lane_merge({3'h0, aen3_r}, wdat_w, sel_i[1:0]);

fca_unlock u_unlock
(
	.clk_i(clk_i),
	.rst_i(rst_i),
	.key_wr_i(key_wr_w),
	.key_val_i(wdat_w),
	.prot_req_i(prot_req_i),
	.prot_ok_o(prot_ok_o),
	.unlocked_o(unlocked_o)
);

fca_abort #(
	.IRQ_N(IRQ_N)
) u_abort
(
	.clk_i(clk_i),
	.rst_i(rst_i),
	.aen_i(aen_all_w),
	.irq_i(irq_i),
	.op_active_i(op_active_i),
	.trig_o(abort_trig_w),
	.abort_o(abort_o)
);

// Read mux; unmapped addresses and write-only locations read zero
// Page reads rebuild the byte-address view, so software reads back the bits 13:9 it wrote
always @*
begin
	rdat_w = 16'h0000;
	if (sel_page0_w)
		rdat_w = page_view(page0_r);
	else if (sel_page1_w)
		rdat_w = page_view(page1_r);
	else if (sel_key_w)
		rdat_w = 16'h0000;
	else if (sel_sig_low_field_w)
		rdat_w = sig_lo_r;
	else if (sel_sig_high_field_w)
		rdat_w = sig_hi_r;
	else if (sel_abtl_w)
		rdat_w = abt_lo_r;
	else if (sel_abth_w)
		rdat_w = abt_hi_r;
	else if (sel_aen0_w)
		rdat_w = aen0_r;
	else if (sel_aen1_w)
		rdat_w = aen1_r;
	else if (sel_aen2_w)
		rdat_w = aen2_r;
	else if (sel_aen3_w)
		rdat_w = {3'h0, aen3_r};
end

// Bus handshake and read data
// Ack is registered: each access costs two edges, but decode stays off the ack path
// Read data changes only on reads, so a write never disturbs the last value
always @(posedge clk_i)
begin
	if (rst_i)
	begin
		ack_o <= 1'b0;
		dat_o <= 32'h00000000;
	end
	else
	begin
		ack_o <= req_w;
		if (req_w && !we_i)
			dat_o <= {16'h0000, rdat_w};
	end
end

// Page address registers
always @(posedge clk_i)
begin
	if (rst_i)
	begin
		page0_r <= `FCA_RST_PAGE;
		page1_r <= `FCA_RST_PAGE;
	end
	else if (wr_w && sel_i[1])
	begin
		// Bits 13:9 live in the upper lane; lower-lane bits are dropped
		if (sel_page0_w)
			page0_r <= page_wr_w[`FCA_PAGE_MSB:`FCA_PAGE_LSB];
		else if (sel_page1_w)
			page1_r <= page_wr_w[`FCA_PAGE_MSB:`FCA_PAGE_LSB];
	end
end

// Signature result, loaded by the command engine when a signature completes
// The upper half has no defined reset value; zero keeps early reads deterministic
always @(posedge clk_i)
begin
	if (rst_i)
	begin
		sig_lo_r <= `FCA_RST_HALF;
		sig_hi_r <= `FCA_RST_HALF;
	end
	else if (sig_load_i)
	begin
		sig_lo_r <= sig_value_i[15:0];
		sig_hi_r <= sig_value_i[31:16];
	end
end

// Abort address; a capture beats a software write in the same cycle
// The upper half is loaded only by a capture, never by software
always @(posedge clk_i)
begin
	if (rst_i)
	begin
		abt_lo_r <= `FCA_RST_HALF;
		abt_hi_r <= `FCA_RST_HALF;
	end
	else if (abort_trig_w && write_active_i)
	begin
		abt_lo_r <= write_addr_i[15:0];
		abt_hi_r <= write_addr_i[31:16];
	end
	else if (wr_w && sel_abtl_w)
	begin
		abt_lo_r <= lane_merge(abt_lo_r, wdat_w, sel_i[1:0]);
	end
end

// Abort enable registers
// Lanes merge, so a byte write leaves the other enables untouched
always @(posedge clk_i)
begin
	if (rst_i)
	begin
		aen0_r <= `FCA_RST_HALF;
		aen1_r <= `FCA_RST_HALF;
		aen2_r <= `FCA_RST_HALF;
		aen3_r <= `FCA_RST_AEN3;
	end
	else if (wr_w)
	begin
		if (sel_aen0_w)
			aen0_r <= lane_merge(aen0_r, wdat_w, sel_i[1:0]);
		else if (sel_aen1_w)
			aen1_r <= lane_merge(aen1_r, wdat_w, sel_i[1:0]);
		else if (sel_aen2_w)
			aen2_r <= lane_merge(aen2_r, wdat_w, sel_i[1:0]);
		else if (sel_aen3_w)
			aen3_r <= aen3_wr_w[`FCA_AEN3_W-1:0];
	end
end

endmodule
`default_nettype wire

// ### logic/fca_unlock.v
// Two-step key unlock for protected flash commands.
// Assumes key writes arrive as single-cycle strobes from the register slave.
`timescale 1ns/1ps
`default_nettype none
`include "fca_map.vh"

module fca_unlock
(
	// System
	input wire clk_i,
	input wire rst_i,
	// Key write strobe from the register slave
	input wire key_wr_i,
	input wire [15:0] key_val_i,
	// Protected command handshake
	input wire prot_req_i,
	output wire prot_ok_o,
	output wire unlocked_o
);

localparam ST_LOCKED = 3'b001;
localparam ST_HALF = 3'b010;
localparam ST_OPEN = 3'b100;

reg [2:0] state_r;
reg [2:0] state_nxt;

// A protected command is taken only while unlocked
assign prot_ok_o = prot_req_i & (state_r == ST_OPEN);
assign unlocked_o = (state_r == ST_OPEN);

always @*
begin
	state_nxt = state_r;
	case (state_r)
		ST_LOCKED:
		begin
			if (key_wr_i && key_val_i == `FCA_KEY_FIRST)
				state_nxt = ST_HALF;
		end
		ST_HALF:
		begin
			// Any other value cancels; a repeated first key restarts the sequence
			if (key_wr_i)
			begin
				if (key_val_i == `FCA_KEY_SECOND)
					state_nxt = ST_OPEN;
				else if (key_val_i == `FCA_KEY_FIRST)
					state_nxt = ST_HALF;
				else
					state_nxt = ST_LOCKED;
			end
		end
		ST_OPEN:
		begin
			// A key write overrides consumption in the same cycle
			if (key_wr_i)
				state_nxt = (key_val_i == `FCA_KEY_FIRST) ? ST_HALF : ST_LOCKED;
			else if (prot_req_i)
				state_nxt = ST_LOCKED;
		end
		default:
		begin
			state_nxt = ST_LOCKED;
		end
	endcase
end

always @(posedge clk_i)
begin
	if (rst_i)
		state_r <= ST_LOCKED;
	else
		state_r <= state_nxt;
end

endmodule
`default_nettype wire

// ### sim/fca_flash_model.sv
// Behavioural flash controller side and interrupt sources.
// Driven by task calls from the bench, always just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module fca_flash_model #(parameter IRQ_N = 61) (
	// System
	input wire logic clk_i,
	// From the block
	input wire logic prot_ok_i,
	input wire logic abort_i,
	// To the block
	output logic prot_req_o,
	output logic sig_load_o,
	output logic [31:0] sig_value_o,
	output logic write_active_o,
	output logic [31:0] write_addr_o,
	output logic op_active_o,
	output logic [IRQ_N-1:0] irq_o
);
	initial
	begin
		prot_req_o = 1'b0;
		sig_load_o = 1'b0;
		sig_value_o = 32'h0;
		write_active_o = 1'b0;
		write_addr_o = 32'h0;
		op_active_o = 1'b0;
		irq_o = '0;
	end
	// Signature runs only when the protected request is granted
	task sign(input logic [31:0] v, output logic ok);
		prot_req_o <= 1'b1;
		@(posedge clk_i);
		ok = prot_ok_i;
		prot_req_o <= 1'b0;
		sig_load_o <= ok;
		sig_value_o <= v;
		@(posedge clk_i);
		sig_load_o <= 1'b0;
		sig_value_o <= ~v;
	endtask
	task wr_abort(input logic [31:0] a, input int n, output logic hit);
		op_active_o <= 1'b1;
		write_active_o <= 1'b1;
		write_addr_o <= a;
		irq_o[n] <= 1'b1;
		hit = 1'b0;
		repeat (4)
		begin
			@(posedge clk_i);
			hit = hit | abort_i;
		end
		op_active_o <= 1'b0;
		write_active_o <= 1'b0;
		// Released address bus does not keep the last value
		write_addr_o <= ~a;
		irq_o <= '0;
		@(posedge clk_i);
	endtask
endmodule
`default_nettype wire

// ### sim/fca_regs_properties.sv
// Checker for the flash auxiliary register block.
// Sees only the top ports; bound to every instance of the top.
`timescale 1ns/1ps
`default_nettype none
`include "fca_map.vh"
module fca_regs_properties #(parameter IRQ_N = 61) (
	// System
	input wire logic clk_i,
	input wire logic rst_i,
	// Bus
	input wire logic [31:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic we_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	// Command side
	input wire logic [4:0] first_page_addr_o,
	input wire logic prot_req_i,
	input wire logic prot_ok_o,
	input wire logic unlocked_o,
	input wire logic op_active_i,
	input wire logic [IRQ_N-1:0] irq_i,
	input wire logic abort_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic key_q = 1'b0;
	logic cause_q = 1'b0;
	// Master holds the request through the ack cycle
	wire logic rd = ack_o && !we_i;
	always @(posedge clk_i)
	begin
		key_q <= cyc_i && stb_i && !ack_o && we_i && adr_i == `FCA_ADR_KEY && dat_i[15:0] == `FCA_KEY_SECOND;
		cause_q <= op_active_i && |irq_i;
	end
	AST_ACK_ONE: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("request not acked next cycle");
	AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	AST_DAT_HI: assert property (ack_o |-> dat_o[31:16] == 16'h0000)
		else $error("upper read data not zero");
	AST_PAGE_RD: assert property (
		rd && adr_i == `FCA_ADR_PAGE0 |-> dat_o[15:0] == {2'b00, first_page_addr_o, 9'h000})
		else $error("page read mismatch");
	AST_KEY_RD: assert property (rd && adr_i == `FCA_ADR_KEY |-> dat_o == 32'h0)
		else $error("key read not zero");
	AST_AEN3_RD: assert property (rd && adr_i == `FCA_ADR_AEN3 |-> dat_o[15:13] == 3'h0)
		else $error("reserved enable bits not zero");
	AST_PROT: assert property (prot_ok_o == (prot_req_i && unlocked_o))
		else $error("grant mismatch");
	AST_USE: assert property (prot_ok_o |=> !unlocked_o)
		else $error("unlock not consumed");
	AST_UNLOCK: assert property ($rose(unlocked_o) |-> key_q)
		else $error("unlock without second key");
	AST_ABORT: assert property (abort_o |-> cause_q ##1 !abort_o)
		else $error("abort without cause or too long");
	cover property (prot_ok_o);
	cover property (abort_o);
	cover property ($rose(unlocked_o));
endmodule
bind fca_regs fca_regs_properties #(.IRQ_N(IRQ_N)) chk_u (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i,
	.cyc_i, .stb_i, .ack_o, .first_page_addr_o, .prot_req_i, .prot_ok_o, .unlocked_o, .op_active_i, .irq_i, .abort_o);
`default_nettype wire

// ### sim/fca_regs_tb.sv
// Self-checking bench for the flash auxiliary registers.
// Needs the design, the flash model and the checker; one 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "fca_map.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; $display("unexpected %0t value %h, want %h", $time, g, e); end end
module fca_regs_tb;
	logic clk_i = 0;
	logic rst_i = 1;
	logic [31:0] adr_i = 0;
	logic [31:0] dat_i = 0;
	logic we_i = 0;
	logic [3:0] sel_i = 0;
	logic cyc_i = 0;
	logic stb_i = 0;
	wire logic [31:0] dat_o, sig_value_i, write_addr_i;
	wire logic ack_o, prot_req_i, prot_ok_o, unlocked_o, sig_load_i, write_active_i, op_active_i, abort_o;
	wire logic [4:0] first_page_addr_o, second_page_addr_o;
	wire logic [60:0] irq_i;
	int failures = 0;
	int checked = 0;
	logic ok;
	logic [15:0] q;
	// Page0 page1 key sig_low_field sig_high_field abtl abth aen0-3 hole
	logic [31:0] map [12] = '{`FCA_ADR_PAGE0, `FCA_ADR_PAGE1, `FCA_ADR_KEY, `FCA_ADR_SIG_LOW_FIELD, `FCA_ADR_SIG_HIGH_FIELD,
		`FCA_ADR_ABTL, `FCA_ADR_ABTH, `FCA_ADR_AEN0, `FCA_ADR_AEN1, `FCA_ADR_AEN2, `FCA_ADR_AEN3, 32'h4001c000};
	always #5 clk_i = ~clk_i;
	fca_regs dut_u (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i, .cyc_i, .stb_i, .ack_o,
		.first_page_addr_o, .second_page_addr_o, .prot_req_i, .prot_ok_o, .unlocked_o, .sig_load_i,
		.sig_value_i, .write_active_i, .write_addr_i, .op_active_i, .irq_i, .abort_o);
	fca_flash_model fl_u (.clk_i, .prot_ok_i(prot_ok_o), .abort_i(abort_o), .prot_req_o(prot_req_i),
		.sig_load_o(sig_load_i), .sig_value_o(sig_value_i), .write_active_o(write_active_i),
		.write_addr_o(write_addr_i), .op_active_o(op_active_i), .irq_o(irq_i));
	task test_done;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task wb(input logic [31:0] a, input logic w, input logic [15:0] d);
		int n;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		adr_i <= a;
		we_i <= w;
		sel_i <= 4'hf;
		dat_i <= {16'h0000, d};
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack_o !== 1'b1 && n < 20);
		q = dat_o[15:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
		if (n >= 20)
		begin
			failures++;
			test_done;
		end
	endtask
	task rd(input logic [31:0] a, input logic [15:0] e);
		wb(a, 1'b0, 16'h0000);
		`CHK(q, e)
	endtask
	initial
	begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		foreach (map[i]) rd(map[i], 16'h0000);
		$display("test reset done");
		wb(map[0], 1'b1, 16'hffff);
		rd(map[0], 16'h3e00);
		`CHK(first_page_addr_o, 5'h1f)
		wb(map[3], 1'b1, 16'h1234);
		rd(map[3], 16'h0000);
		for (int i = 7; i < 11; i++)
		begin
			wb(map[i], 1'b1, 16'hffff);
			rd(map[i], i == 10 ? 16'h1fff : 16'hffff);
		end
		$display("test registers done");
		fl_u.sign(32'h0bad0bad, ok);
		`CHK(ok, 1'b0)
		wb(map[0], 1'b1, 16'h0400);
		wb(map[1], 1'b1, 16'h0a00);
		`CHK(first_page_addr_o, 5'h02)
		`CHK(second_page_addr_o, 5'h05)
		wb(map[2], 1'b1, 16'hf456);
		wb(map[2], 1'b1, 16'hf123);
		`CHK(unlocked_o, 1'b1)
		rd(map[2], 16'h0000);
		fl_u.sign(32'hcafe1234, ok);
		`CHK({ok, unlocked_o}, 2'b10)
		rd(map[3], 16'h1234);
		rd(map[4], 16'hcafe);
		wb(map[2], 1'b1, 16'hf456);
		wb(map[2], 1'b1, 16'h1111);
		wb(map[2], 1'b1, 16'hf123);
		`CHK(unlocked_o, 1'b0)
		$display("test unlock done");
		wb(map[7], 1'b1, 16'hffdf);
		fl_u.wr_abort(32'h00055aa0, 5, ok);
		`CHK(ok, 1'b0)
		fl_u.wr_abort(32'h00012344, 60, ok);
		`CHK(ok, 1'b1)
		rd(map[5], 16'h2344);
		wb(map[5], 1'b1, 16'h5555);
		wb(map[6], 1'b1, 16'h7777);
		rd(map[5], 16'h5555);
		rd(map[6], 16'h0001);
		$display("test abort done");
		test_done;
	end
endmodule
`default_nettype wire
